/* File: hw/pwd_pkg.sv */
// constants and types for the prefetch window decode block
package pwd_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] PWD_OFF_PREF_LOW = 8'h24;
  localparam logic [7:0] PWD_OFF_PREF_BASE_HI = 8'h28;
  localparam logic [7:0] PWD_OFF_PREF_LIMIT_HI = 8'h2c;
  localparam logic [7:0] PWD_OFF_IO_HI = 8'h30;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam logic [3:0] PWD_ADDR64_IND = 4'h1;
  localparam int PWD_BASE_LSB = 4;
  localparam int PWD_LIMIT_LSB = 20;
  localparam int PWD_MEM_GRAN_BITS = 20;
  localparam int PWD_IO_GRAN_BITS = 12;
  localparam logic [19:0] PWD_MEM_LOW_ONES = 20'hfffff;
  localparam logic [11:0] PWD_IO_LOW_ONES = 12'hfff;
  localparam logic [11:0] PWD_FIELD12_RST = 12'h000;
  localparam logic [15:0] PWD_FIELD16_RST = 16'h0000;
  localparam logic [31:0] PWD_WORD_RST = 32'h0000_0000;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PWD_RD_IDLE = 2'b01,
    PWD_RD_DATA = 2'b10
  } pwd_rd_state_t;
endpackage : pwd_pkg

/* File: hw/pwd_range_cmp.sv */
// inclusive range compare of memory and io addresses against window bounds
module pwd_range_cmp
  import pwd_pkg::*;
(
  // window bounds
  pwd_win_if.dst win,
  // addresses under test
  input wire logic [63:0] mem_addr,
  input wire logic [31:0] io_addr,
  // results
  output logic mem_hit,
  output logic io_hit
);
  function automatic logic in_range64(input logic [63:0] a, input logic [63:0] lo,
                                      input logic [63:0] hi);
    in_range64 = (a >= lo) && (a <= hi);
  endfunction : in_range64

  always_comb begin
    mem_hit = in_range64(mem_addr, win.mem_base, win.mem_limit);
    io_hit = in_range64({32'h0000_0000, io_addr}, {32'h0000_0000, win.io_base},
                        {32'h0000_0000, win.io_limit});
  end
endmodule : pwd_range_cmp

/* File: hw/pwd_top.sv */
// prefetch and io window registers with forwarding decode
module pwd_top
  import pwd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_offset,
  input wire logic [3:0] primary_cmd_byte_enables_b,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // forwarding decode
  input wire logic [63:0] mem_addr,
  input wire logic [31:0] io_addr,
  output logic mem_fwd,
  output logic io_fwd
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [11:0] pbase_r, pbase_nxt;
  logic [11:0] plimit_r, plimit_nxt;
  logic [31:0] pbase_hi_r, pbase_hi_nxt;
  logic [31:0] plimit_hi_r, plimit_hi_nxt;
  logic [15:0] io_base_hi_r, io_base_hi_nxt;
  logic [15:0] io_limit_hi_r, io_limit_hi_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  pwd_rd_state_t rd_state_r, rd_state_nxt;
  logic mem_hit, io_hit;
  logic mem_fwd_r, mem_fwd_nxt, io_fwd_r, io_fwd_nxt;
  logic [3:0] be;

  // byte enables arrive active low as on the bus
  assign be = ~primary_cmd_byte_enables_b;

  // merge write data into a 32-bit view under byte enables
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] en);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (en[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    merge_be = r;
  endfunction : merge_be

  // ----------------------------------------
  // dword images
  // ----------------------------------------
  function automatic logic [31:0] img_pref_low(input logic [11:0] b, input logic [11:0] l);
    img_pref_low = {l, PWD_ADDR64_IND, b, PWD_ADDR64_IND};
  endfunction : img_pref_low

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    pbase_nxt = pbase_r;
    plimit_nxt = plimit_r;
    pbase_hi_nxt = pbase_hi_r;
    plimit_hi_nxt = plimit_hi_r;
    io_base_hi_nxt = io_base_hi_r;
    io_limit_hi_nxt = io_limit_hi_r;
    if (cfg_wr) begin
      unique case (cfg_offset)
        PWD_OFF_PREF_LOW: begin
          m = merge_be(img_pref_low(pbase_r, plimit_r), cfg_wdata, be);
          pbase_nxt = m[15:PWD_BASE_LSB];
          plimit_nxt = m[31:PWD_LIMIT_LSB];
        end
        PWD_OFF_PREF_BASE_HI: begin
          pbase_hi_nxt = merge_be(pbase_hi_r, cfg_wdata, be);
        end
        PWD_OFF_PREF_LIMIT_HI: begin
          plimit_hi_nxt = merge_be(plimit_hi_r, cfg_wdata, be);
        end
        PWD_OFF_IO_HI: begin
          m = merge_be({io_limit_hi_r, io_base_hi_r}, cfg_wdata, be);
          io_base_hi_nxt = m[15:0];
          io_limit_hi_nxt = m[31:16];
        end
        default: begin
          m = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pbase_r <= PWD_FIELD12_RST;
      plimit_r <= PWD_FIELD12_RST;
      pbase_hi_r <= PWD_WORD_RST;
      plimit_hi_r <= PWD_WORD_RST;
      io_base_hi_r <= PWD_FIELD16_RST;
      io_limit_hi_r <= PWD_FIELD16_RST;
    end else if (clk_en) begin
      pbase_r <= pbase_nxt;
      plimit_r <= plimit_nxt;
      pbase_hi_r <= pbase_hi_nxt;
      plimit_hi_r <= plimit_hi_nxt;
      io_base_hi_r <= io_base_hi_nxt;
      io_limit_hi_r <= io_limit_hi_nxt;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // unmapped offsets read zero so neighbouring config space stays clean
  always_comb begin
    rdata_nxt = rdata_r;
    rd_state_nxt = PWD_RD_IDLE;
    if (cfg_rd) begin
      rd_state_nxt = PWD_RD_DATA;
      unique case (cfg_offset)
        PWD_OFF_PREF_LOW: rdata_nxt = img_pref_low(pbase_r, plimit_r);
        PWD_OFF_PREF_BASE_HI: rdata_nxt = pbase_hi_r;
        PWD_OFF_PREF_LIMIT_HI: rdata_nxt = plimit_hi_r;
        PWD_OFF_IO_HI: rdata_nxt = {io_limit_hi_r, io_base_hi_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h0000_0000;
      rd_state_r <= PWD_RD_IDLE;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
      rd_state_r <= rd_state_nxt;
    end
  end

  assign cfg_rdata = rdata_r;
  assign cfg_rvalid = (rd_state_r == PWD_RD_DATA);

  // ----------------------------------------
  // window assembly and decode
  // ----------------------------------------
  pwd_win_if win ();

  assign win.mem_base = {pbase_hi_r, pbase_r, {PWD_MEM_GRAN_BITS{1'b0}}};
  assign win.mem_limit = {plimit_hi_r, plimit_r, PWD_MEM_LOW_ONES};
  // lower io window fields live elsewhere; only 64KB-aligned upper bits here
  assign win.io_base = {io_base_hi_r, 4'h0, {PWD_IO_GRAN_BITS{1'b0}}};
  assign win.io_limit = {io_limit_hi_r, 4'hf, PWD_IO_LOW_ONES};

  pwd_range_cmp u_cmp (
    .win(win),
    .mem_addr(mem_addr),
    .io_addr(io_addr),
    .mem_hit(mem_hit),
    .io_hit(io_hit)
  );

  // registered so the wide compare does not sit in the forwarding path
  always_comb begin
    mem_fwd_nxt = mem_hit;
    io_fwd_nxt = io_hit;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_fwd_r <= 1'b0;
      io_fwd_r <= 1'b0;
    end else if (clk_en) begin
      mem_fwd_r <= mem_fwd_nxt;
      io_fwd_r <= io_fwd_nxt;
    end
  end

  assign mem_fwd = mem_fwd_r;
  assign io_fwd = io_fwd_r;
endmodule : pwd_top

/* File: hw/pwd_win_if.sv */
// window bounds carried from register file to range comparator
interface pwd_win_if;
  logic [63:0] mem_base;
  logic [63:0] mem_limit;
  logic [31:0] io_base;
  logic [31:0] io_limit;
  modport src (output mem_base, output mem_limit, output io_base, output io_limit);
  modport dst (input mem_base, input mem_limit, input io_base, input io_limit);
endinterface : pwd_win_if

/* File: tb/pwd_agent_model.sv */
// bus agent model presenting memory and io addresses to the decoder
module pwd_agent_model (
  input wire logic clk,
  input wire logic [63:0] want_mem,
  input wire logic [31:0] want_io,
  output logic [63:0] mem_addr,
  output logic [31:0] io_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial mem_addr = 64'h0;
  initial io_addr = 32'h0;
  // repeated addresses are harmless: the target side has no read side effects
  always @(posedge clk) begin
    mem_addr <= want_mem;
    io_addr <= want_io;
  end
endmodule : pwd_agent_model

/* File: tb/pwd_assertions.sv */
// port checker for the prefetch window decode block
module pwd_checker (
  // watched ports
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_offset,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic [63:0] mem_addr,
  input wire logic [31:0] io_addr,
  input wire logic mem_fwd,
  input wire logic io_fwd
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rd_go = cfg_rd && clk_en;
  wire unmapped = !(cfg_offset inside {8'h24, 8'h28, 8'h2c, 8'h30});
  ro_base_a: assert property (rd_go && cfg_offset == 8'h24 |=>
    cfg_rdata[3:0] == 4'h1) else $error("base nibble wrong");
  ro_limit_a: assert property (rd_go && cfg_offset == 8'h24 |=>
    cfg_rdata[19:16] == 4'h1) else $error("limit nibble wrong");
  rd_answer_a: assert property (rd_go |=> cfg_rvalid)
    else $error("read not answered");
  // a frozen clock enable holds the valid flag, so only judge it after a live edge
  rvalid_cause_a: assert property (cfg_rvalid && $past(clk_en) |-> $past(rd_go))
    else $error("stray read valid");
  unmapped_zero_a: assert property (rd_go && unmapped |=> cfg_rdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_go |=> $stable(cfg_rdata))
    else $error("read data moved");
  mem_gran_a: assert property ((clk_en && !cfg_wr) ##1 (clk_en &&
    mem_addr[63:20] == $past(mem_addr[63:20])) |=> $stable(mem_fwd))
    else $error("memory decode finer than 1MB");
  io_gran_a: assert property ((clk_en && !cfg_wr) ##1 (clk_en &&
    io_addr[31:16] == $past(io_addr[31:16])) |=> $stable(io_fwd))
    else $error("io decode finer than window");
endmodule : pwd_checker
bind pwd_top pwd_checker u_chk (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_offset(cfg_offset), .cfg_rdata(cfg_rdata),
  .cfg_rvalid(cfg_rvalid), .mem_addr(mem_addr), .io_addr(io_addr),
  .mem_fwd(mem_fwd), .io_fwd(io_fwd));

/* File: tb/pwd_top_tb.sv */
// self-checking bench for the prefetch window decode block
module pwd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] o; logic [3:0] b; logic [31:0] d; logic [31:0] e;} pwd_row_t;
  logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [7:0] cfg_offset = 8'h00;
  logic [3:0] be_b = 4'hf;
  logic [31:0] cfg_wdata = 32'h0, want_io = 32'h0, cfg_rdata, io_addr;
  logic [63:0] want_mem = 64'h0, mem_addr;
  logic cfg_rvalid, mem_fwd, io_fwd;
  int mismatches = 0, total_checks = 0, cyc = 0;
  // nibbles read-only, lanes honoured, unmapped ignored
  pwd_row_t rows [7] = '{'{8'h24, 4'h0, 32'hffff_ffff, 32'hfff1_fff1},
    '{8'h24, 4'hc, 32'h0, 32'hfff1_0001}, '{8'h28, 4'h0, 32'h1234_5678, 32'h1234_5678},
    '{8'h2c, 4'h0, 32'h9abc_def0, 32'h9abc_def0}, '{8'h30, 4'h0, 32'h1111_2222, 32'h1111_2222},
    '{8'h28, 4'he, 32'hffff_ffff, 32'h1234_56ff}, '{8'h34, 4'h0, 32'hffff_ffff, 32'h0}};
  always #50 clk = ~clk;
  pwd_top DUT (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_offset(cfg_offset), .primary_cmd_byte_enables_b(be_b), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .mem_addr(mem_addr), .io_addr(io_addr),
    .mem_fwd(mem_fwd), .io_fwd(io_fwd));
  pwd_agent_model agent (.clk(clk), .want_mem(want_mem), .want_io(want_io),
    .mem_addr(mem_addr), .io_addr(io_addr));
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] o, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_offset <= o;
    be_b <= b;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] o, input logic [31:0] e);
    @(posedge clk);
    cfg_rd <= 1'b1;
    cfg_offset <= o;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    chk("cfg_rvalid", 64'h1, {63'h0, cfg_rvalid});
    chk("cfg_rdata", {32'h0, e}, {32'h0, cfg_rdata});
  endtask : rd
  // one edge into the agent, one into the decoder, one spare
  task automatic dec(input logic [63:0] m, input logic [31:0] i, input logic em, input logic ei);
    @(posedge clk);
    want_mem <= m;
    want_io <= i;
    repeat (3) @(posedge clk);
    #1;
    chk("mem_fwd", {63'h0, em}, {63'h0, mem_fwd});
    chk("io_fwd", {63'h0, ei}, {63'h0, io_fwd});
  endtask : dec
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k].o, rows[k].b, rows[k].d);
      rd(rows[k].o, rows[k].e);
    end
    $display("register rows done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h24, 32'h0001_0001);
    rd(8'h28, 32'h0);
    rd(8'h2c, 32'h0);
    rd(8'h30, 32'h0);
    $display("second reset done");
    wr(8'h24, 4'h0, 32'h1241_1231);
    wr(8'h28, 4'h0, 32'h1);
    wr(8'h2c, 4'h0, 32'h1);
    wr(8'h30, 4'h0, 32'h0005_0003);
    dec(64'h1_122f_ffff, 32'h0002_ffff, 1'b0, 1'b0);
    dec(64'h1_1230_0000, 32'h0003_0000, 1'b1, 1'b1);
    dec(64'h1_124f_ffff, 32'h0005_ffff, 1'b1, 1'b1);
    dec(64'h1_1250_0000, 32'h0006_0000, 1'b0, 1'b0);
    dec(64'h0_1230_0000, 32'h0004_0fff, 1'b0, 1'b1);
    dec(64'h2_1230_0000, 32'h0003_f000, 1'b0, 1'b1);
    $display("decode done");
    // frozen enable: write ignored, decode output held, then both resume
    @(posedge clk);
    clk_en <= 1'b0;
    want_mem <= 64'h1_1230_0000;
    wr(8'h28, 4'h0, 32'hdead_beef);
    #1;
    chk("mem_fwd", 64'h0, {63'h0, mem_fwd});
    @(posedge clk);
    clk_en <= 1'b1;
    rd(8'h28, 32'h1);
    chk("mem_fwd", 64'h1, {63'h0, mem_fwd});
    $display("clock enable done");
    stop_test();
  end
endmodule : pwd_top_tb
